//--- core/acdp_pkg.sv
// Package for the auxiliary control and dual data pointer block.
// Assumes a single 40 MHz core clock and Avalon-MM register access.
package acdp_pkg;
	// Register word addresses (byte address = index * 4)
	localparam logic [3:0] ADDR_AUX_CTRL = 4'h0;
	localparam logic [3:0] ADDR_PTR_LOW = 4'h1;
	localparam logic [3:0] ADDR_PTR_HIGH = 4'h2;
	localparam logic [3:0] ADDR_PTR_OP = 4'h3;
	localparam logic [3:0] ADDR_PTR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_CFG_ADDR = 4'h5;
	localparam logic [3:0] ADDR_CFG_DATA = 4'h6;
	// Auxiliary control field positions
	localparam int BIT_SELECT = 0;
	localparam int BIT_RSVD = 1;
	localparam int BIT_ZERO = 2;
	localparam int BIT_SOFT_RESET = 3;
	localparam int BIT_BROWNOUT_OFF = 6;
	localparam logic [7:0] AUX_RESET = 8'h00;
	// Bits software may store; bit 2 is never stored, bit 3 is never held
	localparam logic [7:0] AUX_WMASK = 8'hF3;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [15:0] PTR_ONE = 16'h0001;
	localparam logic [15:0] RESTART_ADDR = 16'h0000;
	// Pointer operation codes, written to ADDR_PTR_OP bits [2:0]
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_INC = 3'h1;
	localparam logic [2:0] OP_LOAD = 3'h2;
	localparam logic [2:0] OP_JUMP = 3'h3;
	localparam logic [2:0] OP_CODE_RD = 3'h4;
	localparam logic [2:0] OP_DATA_RD = 3'h5;
	localparam logic [2:0] OP_DATA_WR = 3'h6;
	// Configuration window reached by data-memory accesses
	localparam int CFG_WORDS = 4;
	localparam logic [15:0] CFG_BASE = 16'hFD00;
	// Cycles the soft reset pulse is held
	localparam int RESET_NS = 100;
	localparam int CLK_MHZ = 40;
	localparam int RESET_CYCLES = (RESET_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [1:0] {
		ACDP_IDLE = 2'b00,
		ACDP_RESP = 2'b01
	} acdp_bus_t;
endpackage

//--- core/acdp_ptr_pair.sv
// Holds the two 16-bit data pointers and applies the selected update.
// Assumes the caller presents at most one update per cycle.
`timescale 1ns/1ps
module acdp_ptr_pair (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic select,
	input wire logic inc,
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wr_byte,
	output logic [15:0] active
);
	logic [15:0] ptr_q [2];
	logic [15:0] ptr_d [2];

	always_comb begin
		ptr_d = ptr_q;
		if (clear) begin
			ptr_d[0] = acdp_pkg::PTR_RESET;
			ptr_d[1] = acdp_pkg::PTR_RESET;
		end else if (inc) begin
			ptr_d[select] = ptr_q[select] + acdp_pkg::PTR_ONE; // RULE3
		end else if (load) begin
			ptr_d[select] = load_val; // RULE3
		end else if (wr_low) begin
			ptr_d[select][7:0] = wr_byte; // RULE4
		end else if (wr_high) begin
			ptr_d[select][15:8] = wr_byte; // RULE4
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q[0] <= acdp_pkg::PTR_RESET;
			ptr_q[1] <= acdp_pkg::PTR_RESET;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	// Only the selected pointer is visible outside
	assign active = ptr_q[select]; // RULE2
endmodule // acdp_ptr_pair

//--- core/acdp_aux_ctrl.sv
// Auxiliary control register with soft reset, dual data pointers and
// brownout disable, reached over Avalon-MM with waitrequest.
// Assumes the core clock at 40 MHz and a host that holds each request.
//
// Notes on behaviour
// RULE1: Writing bit 3 resets the whole chip
// RULE2: Two pointers; select bit hides the other
// RULE3: Pointer operations use the selected pointer
// RULE4: Byte register access hits selected pointer
// RULE5: Bit 2 reads zero, ignores writes
// RULE6: Data accesses reach only configuration bytes
// RULE7: Brownout off bit disables detector
// RULE8: Software avoids setting reset bit accidentally
// RULE9: Register returns to reset value afterwards
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module acdp_aux_ctrl (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic chip_reset_req,
	output logic [15:0] restart_pc,
	output logic [15:0] jump_target,
	output logic jump_valid,
	output logic [15:0] code_addr,
	output logic code_rd_valid,
	output logic brownout_detect_en
);
	acdp_pkg::acdp_bus_t state_q, state_d;
	logic [7:0] aux_q, aux_d;
	logic [7:0] cfg_q [acdp_pkg::CFG_WORDS];
	logic [7:0] cfg_d [acdp_pkg::CFG_WORDS];
	logic [31:0] rdata_q, rdata_d;
	logic wait_q, wait_d;
	logic [7:0] rst_cnt_q, rst_cnt_d;
	logic rst_req_q, rst_req_d;
	logic [15:0] jump_q, jump_d;
	logic jv_q, jv_d;
	logic [15:0] caddr_q, caddr_d;
	logic crv_q, crv_d;
	logic bod_en_q, bod_en_d;
	logic [15:0] restart_q;
	logic [7:0] last_cfg_q, last_cfg_d;
	logic cfg_hit_q, cfg_hit_d;
	logic [15:0] data_pointer;
	logic wr_take, rd_take;
	logic p_inc, p_load, p_low, p_high;

	// True when the pointer lands in the configuration window
	function automatic logic cfg_hit(input logic [15:0] a);
		return a >= acdp_pkg::CFG_BASE &&
			a < acdp_pkg::CFG_BASE + 16'(acdp_pkg::CFG_WORDS);
	endfunction

	function automatic logic [1:0] cfg_idx(input logic [15:0] a);
		logic [15:0] off;
		off = a - acdp_pkg::CFG_BASE;
		return off[1:0];
	endfunction

	assign wr_take = (state_q == acdp_pkg::ACDP_IDLE) && avs_write && avs_byteenable[0];
	assign rd_take = (state_q == acdp_pkg::ACDP_IDLE) && avs_read;
	wire logic [2:0] op_code = avs_writedata[2:0];
	wire logic is_op = wr_take && (avs_address == acdp_pkg::ADDR_PTR_OP);
	assign p_inc = is_op && (op_code == acdp_pkg::OP_INC);
	assign p_load = is_op && (op_code == acdp_pkg::OP_LOAD);
	assign p_low = wr_take && (avs_address == acdp_pkg::ADDR_PTR_LOW);
	assign p_high = wr_take && (avs_address == acdp_pkg::ADDR_PTR_HIGH);

	acdp_ptr_pair u_ptrs (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(rst_req_q),
		.select(aux_q[acdp_pkg::BIT_SELECT]),
		.inc(p_inc),
		.load(p_load),
		.load_val(avs_writedata[31:16]),
		.wr_low(p_low),
		.wr_high(p_high),
		.wr_byte(avs_writedata[7:0]),
		.active(data_pointer)
	);

	// Bus handshake: every access answers one cycle after it is taken
	always_comb begin
		state_d = state_q;
		wait_d = 1'b1;
		unique case (state_q)
			acdp_pkg::ACDP_IDLE: begin
				if (avs_read || avs_write) begin
					state_d = acdp_pkg::ACDP_RESP;
					wait_d = 1'b0;
				end
			end
			acdp_pkg::ACDP_RESP: begin
				state_d = acdp_pkg::ACDP_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= acdp_pkg::ACDP_IDLE;
			wait_q <= 1'b1;
		end else begin
			state_q <= state_d;
			wait_q <= wait_d;
		end
	end

	// Register contents, pointer operations and soft reset
	always_comb begin
		aux_d = aux_q;
		cfg_d = cfg_q;
		rst_cnt_d = rst_cnt_q;
		rst_req_d = rst_req_q;
		jump_d = jump_q;
		jv_d = 1'b0;
		caddr_d = caddr_q;
		crv_d = 1'b0;
		last_cfg_d = last_cfg_q;
		cfg_hit_d = cfg_hit_q;
		if (rst_req_q) begin
			aux_d = acdp_pkg::AUX_RESET; // RULE9
			for (int i = 0; i < acdp_pkg::CFG_WORDS; i++) begin
				cfg_d[i] = 8'h00;
			end
			if (rst_cnt_q == 8'h00) begin
				rst_req_d = 1'b0;
			end else begin
				rst_cnt_d = rst_cnt_q - 8'h01;
			end
		end else if (wr_take) begin
			unique case (avs_address)
				acdp_pkg::ADDR_AUX_CTRL: begin
					// Bit 2 dropped, bit 3 never stored
					aux_d = avs_writedata[7:0] & acdp_pkg::AUX_WMASK; // RULE5
					if (avs_writedata[acdp_pkg::BIT_SOFT_RESET]) begin // RULE1
						// Keep the written bits out so brownout and select do not glitch
						aux_d = acdp_pkg::AUX_RESET;
						rst_req_d = 1'b1;
						rst_cnt_d = 8'(acdp_pkg::RESET_CYCLES - 1);
					end
				end
				acdp_pkg::ADDR_PTR_OP: begin
					if (op_code == acdp_pkg::OP_JUMP) begin
						jump_d = data_pointer + 16'(avs_writedata[15:8]); // RULE3
						jv_d = 1'b1;
					end else if (op_code == acdp_pkg::OP_CODE_RD) begin
						caddr_d = data_pointer + 16'(avs_writedata[15:8]); // RULE3
						crv_d = 1'b1;
					end else if (op_code == acdp_pkg::OP_DATA_RD) begin
						cfg_hit_d = cfg_hit(data_pointer); // RULE6
						last_cfg_d = cfg_hit(data_pointer) ? cfg_q[cfg_idx(data_pointer)] : 8'h00;
					end else if (op_code == acdp_pkg::OP_DATA_WR && cfg_hit(data_pointer)) begin
						cfg_d[cfg_idx(data_pointer)] = avs_writedata[23:16]; // RULE6
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_q <= acdp_pkg::AUX_RESET;
			for (int i = 0; i < acdp_pkg::CFG_WORDS; i++) begin
				cfg_q[i] <= 8'h00;
			end
			rst_cnt_q <= 8'h00;
			rst_req_q <= 1'b0;
			jump_q <= 16'h0000;
			jv_q <= 1'b0;
			caddr_q <= 16'h0000;
			crv_q <= 1'b0;
			last_cfg_q <= 8'h00;
			cfg_hit_q <= 1'b0;
		end else begin
			aux_q <= aux_d;
			cfg_q <= cfg_d;
			rst_cnt_q <= rst_cnt_d;
			rst_req_q <= rst_req_d;
			jump_q <= jump_d;
			jv_q <= jv_d;
			caddr_q <= caddr_d;
			crv_q <= crv_d;
			last_cfg_q <= last_cfg_d;
			cfg_hit_q <= cfg_hit_d;
		end
	end

	// Read data and brownout enable
	always_comb begin
		rdata_d = rdata_q;
		bod_en_d = !aux_q[acdp_pkg::BIT_BROWNOUT_OFF]; // RULE7
		if (rd_take) begin
			unique case (avs_address)
				acdp_pkg::ADDR_AUX_CTRL: rdata_d = {24'h000000, aux_q}; // RULE5
				acdp_pkg::ADDR_PTR_LOW: rdata_d = {24'h000000, data_pointer[7:0]}; // RULE4
				acdp_pkg::ADDR_PTR_HIGH: rdata_d = {24'h000000, data_pointer[15:8]}; // RULE4
				acdp_pkg::ADDR_PTR_STATUS: rdata_d = {16'h0000, data_pointer}; // RULE2
				acdp_pkg::ADDR_CFG_ADDR: rdata_d = {16'h0000, caddr_q};
				acdp_pkg::ADDR_CFG_DATA: rdata_d = {23'h000000, cfg_hit_q, last_cfg_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h00000000;
			bod_en_q <= 1'b1;
			restart_q <= acdp_pkg::RESTART_ADDR;
		end else begin
			rdata_q <= rdata_d;
			bod_en_q <= bod_en_d;
			restart_q <= acdp_pkg::RESTART_ADDR;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign chip_reset_req = rst_req_q; // RULE1
	assign restart_pc = restart_q; // RULE1
	assign jump_target = jump_q;
	assign jump_valid = jv_q;
	assign code_addr = caddr_q;
	assign code_rd_valid = crv_q;
	assign brownout_detect_en = bod_en_q;
endmodule // acdp_aux_ctrl

//--- dv/acdp_aux_ctrl_chk.sv
// Checker for the auxiliary control block, bound to its top module.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module acdp_aux_ctrl_chk (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic chip_reset_req,
	input wire logic [15:0] restart_pc,
	input wire logic jump_valid,
	input wire logic code_rd_valid,
	input wire logic brownout_detect_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic aux_wr;
	logic aux_rd;
	assign aux_wr = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
	assign aux_rd = avs_read && !avs_waitrequest && avs_address == 4'h0;
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_take_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		&& $past(avs_waitrequest) && !chip_reset_req |=> !avs_waitrequest)
		else $error("request not answered");
	// The write is taken one edge before waitrequest is seen low
	a_soft_go: assert property (aux_wr && avs_writedata[3] && !$past(chip_reset_req)
		|-> chip_reset_req) else $error("soft reset missing");
	a_pulse_len: assert property ($rose(chip_reset_req)
		|-> chip_reset_req[*4] ##1 !chip_reset_req) else $error("reset pulse length");
	a_restart_zero: assert property (restart_pc == 16'h0000)
		else $error("restart address");
	a_zero_bit: assert property (aux_rd |-> avs_readdata[3:2] == 2'h0
		&& avs_readdata[31:8] == 24'h0) else $error("aux fixed bits");
	a_brown_off: assert property (aux_wr && !avs_writedata[3] && !$past(chip_reset_req)
		|-> ##2 brownout_detect_en == !$past(avs_writedata[6], 2)) else $error("brownout");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h6
		|-> avs_readdata == 32'h0) else $error("unmapped read");
	a_jump_pulse: assert property (jump_valid |=> !jump_valid)
		else $error("jump pulse");
	a_code_pulse: assert property (code_rd_valid |=> !code_rd_valid)
		else $error("code pulse");
	cover property (aux_wr && avs_writedata[3]);
	cover property (jump_valid);
	cover property (code_rd_valid);
endmodule // acdp_aux_ctrl_chk

bind acdp_aux_ctrl acdp_aux_ctrl_chk i_acdp_aux_ctrl_chk (.core_clk(core_clk), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.chip_reset_req(chip_reset_req), .restart_pc(restart_pc), .jump_valid(jump_valid),
	.code_rd_valid(code_rd_valid), .brownout_detect_en(brownout_detect_en));

//--- dv/test_aux_control_dual_pointer.sv
// Self-checking bench for the auxiliary control block.
// Assumes each request is answered by one low cycle of waitrequest.
`timescale 1ns/1ps
module test_aux_control_dual_pointer;
	logic core_clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic avs_waitrequest, chip_reset_req, jump_valid, code_rd_valid, brownout_detect_en;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [15:0] restart_pc, jump_target, code_addr, r = 16'h424E, p0, p1, jt, ct;
	int error_cnt = 0, comparisons = 0;
	acdp_aux_ctrl i_acdp_aux_ctrl (.core_clk(core_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.chip_reset_req(chip_reset_req), .restart_pc(restart_pc),
		.jump_target(jump_target), .jump_valid(jump_valid), .code_addr(code_addr),
		.code_rd_valid(code_rd_valid), .brownout_detect_en(brownout_detect_en));
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (jump_valid === 1'b1) jt <= jump_target;
	always @(posedge core_clk) if (code_rd_valid === 1'b1) ct <= code_addr;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] aux_exp(input logic [7:0] v);
		return {24'h0, v & acdp_pkg::AUX_WMASK};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		// Hold the request until waitrequest is seen low at an edge
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n == 50) error_cnt++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic op(input logic [2:0] c, input logic [15:0] hi, input logic [7:0] off);
		bus(1'b1, acdp_pkg::ADDR_PTR_OP, {hi, off, 5'h0, c});
	endtask
	task automatic complete_run;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#500000;
		error_cnt++;
		complete_run;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0);
		chk("aux", 32'h0, q);
		chk("bod", 32'h1, {31'h0, brownout_detect_en});
		for (int i = 0; i < 8; i++) begin
			r = lfsr(r);
			bus(1'b1, 4'h0, {24'h0, r[7:0] & 8'hF7});
			repeat (2) @(posedge core_clk);
			chk("bod", {31'h0, !r[6]}, {31'h0, brownout_detect_en});
			bus(1'b0, 4'h0, 32'h0);
			chk("aux", aux_exp(r[7:0]), q);
		end
		avs_byteenable <= 4'hE;
		bus(1'b1, 4'h0, 32'hF7);
		avs_byteenable <= 4'hF;
		bus(1'b0, 4'h0, 32'h0);
		chk("aux", aux_exp(r[7:0]), q);
		p0 = lfsr(r);
		p1 = lfsr(p0);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h1, {24'h0, p0[7:0]});
		bus(1'b1, 4'h2, {24'h0, p0[15:8]});
		bus(1'b1, 4'h0, 32'h1);
		op(acdp_pkg::OP_LOAD, p1, 8'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("ptr", {16'h0, p1}, q);
		bus(1'b0, 4'h0, 32'h0);
		bus(1'b1, 4'h0, q + 32'h1);
		bus(1'b0, 4'h4, 32'h0);
		chk("ptr", {16'h0, p0}, q);
		bus(1'b0, 4'h1, 32'h0);
		chk("low", {24'h0, p0[7:0]}, q);
		p0 = p0 + 16'h1;
		op(acdp_pkg::OP_INC, 16'h0, 8'h0);
		bus(1'b0, 4'h2, 32'h0);
		chk("high", {24'h0, p0[15:8]}, q);
		op(acdp_pkg::OP_JUMP, 16'h0, 8'h5A);
		repeat (3) @(posedge core_clk);
		chk("jump", {16'h0, p0 + 16'h5A}, {16'h0, jt});
		op(acdp_pkg::OP_CODE_RD, 16'h0, 8'hA5);
		bus(1'b0, 4'h5, 32'h0);
		chk("code", {16'h0, p0 + 16'hA5}, q);
		chk("code_pin", {16'h0, p0 + 16'hA5}, {16'h0, ct});
		op(acdp_pkg::OP_LOAD, acdp_pkg::CFG_BASE + 16'h1, 8'h0);
		op(acdp_pkg::OP_DATA_WR, {8'h0, r[7:0]}, 8'h0);
		op(acdp_pkg::OP_DATA_RD, 16'h0, 8'h0);
		bus(1'b0, 4'h6, 32'h0);
		chk("cfg", {23'h0, 1'b1, r[7:0]}, q);
		op(acdp_pkg::OP_LOAD, 16'h1234, 8'h0);
		op(acdp_pkg::OP_DATA_RD, 16'h0, 8'h0);
		bus(1'b0, 4'h6, 32'h0);
		chk("miss", 32'h0, q);
		bus(1'b1, 4'h0, 32'h49);
		// A write inside the reset pulse must be dropped
		bus(1'b1, 4'h0, 32'h40);
		repeat (8) @(posedge core_clk);
		bus(1'b0, 4'h0, 32'h0);
		chk("aux", 32'h0, q);
		bus(1'b0, 4'h4, 32'h0);
		chk("ptr", 32'h0, q);
		chk("bod", 32'h1, {31'h0, brownout_detect_en});
		chk("restart", 32'h0, {16'h0, restart_pc});
		bus(1'b0, 4'hF, 32'h0);
		chk("unmapped", 32'h0, q);
		complete_run;
	end
endmodule // test_aux_control_dual_pointer
